/* File: include/dac_pkg.sv */
package dac_pkg;

	localparam logic [11:0] OFS_CODE_CH0 = 12'h000;
	localparam logic [11:0] OFS_CODE_CH1 = 12'h004;
	localparam logic [11:0] OFS_CONTROL = 12'h008;
	localparam logic [11:0] OFS_MODULE_STOP = 12'h00C;
	localparam logic [11:0] OFS_STATUS = 12'h010;

	localparam int BIT_OE_CH1 = 7;
	localparam int BIT_OE_CH0 = 6;
	localparam int BIT_JOINT = 5;
	localparam logic [4:0] RESERVED_READ = 5'h1F;

	localparam logic [7:0] CODE_RESET = 8'h00;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic MSTOP_RESET = 1'b1;

	localparam int CLK_PERIOD_NS = 4;
	localparam int CONV_TIME_NS = 10000;
	localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;

	typedef struct packed {
		logic [7:0] code;
		logic valid;
		logic drive;
	} dac_out_s;

endpackage

/* File: design/dac_channel.sv */
`timescale 1ns/1ns
module dac_channel
	import dac_pkg::*;
#(
	parameter int CYCLES = CONV_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic convert,
	input wire logic restart,
	input wire logic own_enable,
	input wire logic [7:0] code,
	output dac_out_s out
);
	typedef struct packed {
		logic [31:0] count;
		logic busy;
		logic valid;
		logic [7:0] held;
	} chan_state_s;

	chan_state_s state;
	chan_state_s next_state;

	always_comb begin
		next_state = state;
		if (!convert) begin
			next_state.busy = 1'b0;
			next_state.valid = 1'b0;
			next_state.count = '0;
		end else if (restart || (!state.busy && !state.valid)) begin
			// a rewrite drops the old result and counts afresh
			next_state.busy = 1'b1;
			next_state.valid = 1'b0;
			next_state.count = 32'(CYCLES - 1);
		end else if (state.busy) begin
			if (state.count == '0) begin
				next_state.busy = 1'b0;
				next_state.valid = 1'b1;
				next_state.held = code;
			end else begin
				next_state.count = state.count - 32'd1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// held code stays put until the next conversion completes
	assign out.code = state.held;
	assign out.valid = state.valid;
	assign out.drive = state.valid && own_enable;

endmodule

/* File: design/dual_dac_control.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - two 8-bit code registers, one per channel, readable and writable
// - both code registers reset to zero
// - control bit 7 enables channel 1 conversion and output, resets 0
// - control bit 6 enables channel 0 conversion and output, resets 0
// - bit 5 joint enable: either output enable then converts both channels
// - control bits 4 to 0 read as ones, writes ignored
// - setting an enable starts conversion; result after one conversion interval
// - result held until code rewritten or enable cleared
// - code write to an enabled channel restarts conversion immediately
// - code passed unsigned and unchanged to the converter
// - clearing an enable disables that channel's output
// - standby keeps outputs and enable state unchanged
// - after reset module stop halts the converter until cancelled
// - code and control registers accessible only when module stop cancelled
module dual_dac_control
	import dac_pkg::*;
#(
	parameter int CONV_COUNT = CONV_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic standby,
	output dac_pkg::dac_out_s analog_out_ch0,
	output dac_pkg::dac_out_s analog_out_ch1
);
	import dac_pkg::*;

	typedef struct packed {
		logic [7:0] dac_code_ch0;
		logic [7:0] dac_code_ch1;
		logic out_enable_ch1;
		logic out_enable_ch0;
		logic joint_conv_enable;
		logic module_stop;
		logic wr_pend;
		logic [11:0] wr_addr;
		logic [31:0] rdata;
		logic restart_ch0;
		logic restart_ch1;
	} regs_s;

	regs_s state;
	regs_s next_state;
	logic conv_ch0;
	logic conv_ch1;
	logic addr_phase;

	function automatic logic [7:0] control_byte(input regs_s s);
		control_byte = {s.out_enable_ch1, s.out_enable_ch0, s.joint_conv_enable, RESERVED_READ};
	endfunction

	assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

	always_comb begin
		next_state = state;
		next_state.wr_pend = 1'b0;
		next_state.restart_ch0 = 1'b0;
		next_state.restart_ch1 = 1'b0;
		// data phase of a write lands here; module stop blocks all but a module stop write
		if (state.wr_pend) begin
			if (state.wr_addr == OFS_MODULE_STOP) begin
				next_state.module_stop = hwdata[0];
			end else if (state.module_stop) begin
				next_state.module_stop = state.module_stop;
			end else if (state.wr_addr == OFS_CODE_CH0) begin
				next_state.dac_code_ch0 = hwdata[7:0];
				next_state.restart_ch0 = 1'b1;
			end else if (state.wr_addr == OFS_CODE_CH1) begin
				next_state.dac_code_ch1 = hwdata[7:0];
				next_state.restart_ch1 = 1'b1;
			end else if (state.wr_addr == OFS_CONTROL) begin
				next_state.out_enable_ch1 = hwdata[BIT_OE_CH1];
				next_state.out_enable_ch0 = hwdata[BIT_OE_CH0];
				next_state.joint_conv_enable = hwdata[BIT_JOINT];
			end
		end
		if (addr_phase && hwrite) begin
			next_state.wr_pend = 1'b1;
			next_state.wr_addr = haddr;
		end
		if (addr_phase && !hwrite) begin
			// stopped module reads zero rather than stale state, except the module stop register itself
			if (haddr == OFS_MODULE_STOP) begin
				next_state.rdata = {31'h0, state.module_stop};
			end else if (state.module_stop) begin
				next_state.rdata = 32'h0;
			end else if (haddr == OFS_CODE_CH0) begin
				next_state.rdata = {24'h0, state.dac_code_ch0};
			end else if (haddr == OFS_CODE_CH1) begin
				next_state.rdata = {24'h0, state.dac_code_ch1};
			end else if (haddr == OFS_CONTROL) begin
				next_state.rdata = {24'h0, control_byte(state)};
			end else if (haddr == OFS_STATUS) begin
				next_state.rdata = {30'h0, analog_out_ch1.valid, analog_out_ch0.valid};
			end else begin
				next_state.rdata = 32'h0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state.dac_code_ch0 <= CODE_RESET;
			state.dac_code_ch1 <= CODE_RESET;
			{state.out_enable_ch1, state.out_enable_ch0, state.joint_conv_enable} <= CTRL_RESET;
			state.module_stop <= MSTOP_RESET;
			state.wr_pend <= 1'b0;
			state.wr_addr <= 12'h000;
			state.rdata <= 32'h0;
			state.restart_ch0 <= 1'b0;
			state.restart_ch1 <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign hrdata = state.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// joint mode: either enable converts both; module stop halts all
	// standby is deliberately ignored so outputs are retained
	assign conv_ch0 = !state.module_stop && (state.out_enable_ch0 ||
		(state.joint_conv_enable && state.out_enable_ch1));
	assign conv_ch1 = !state.module_stop && (state.out_enable_ch1 ||
		(state.joint_conv_enable && state.out_enable_ch0));

	dac_channel #(.CYCLES(CONV_COUNT)) u_ch0 (
		.hclk(hclk),
		.hresetn(hresetn),
		.convert(conv_ch0),
		.restart(state.restart_ch0),
		.own_enable(state.out_enable_ch0),
		.code(state.dac_code_ch0),
		.out(analog_out_ch0)
	);

	dac_channel #(.CYCLES(CONV_COUNT)) u_ch1 (
		.hclk(hclk),
		.hresetn(hresetn),
		.convert(conv_ch1),
		.restart(state.restart_ch1),
		.own_enable(state.out_enable_ch1),
		.code(state.dac_code_ch1),
		.out(analog_out_ch1)
	);

	// steps of a conversion and of a bus access
	sequence s_enable_rise0;
		$rose(conv_ch0);
	endsequence

	sequence s_enable_rise1;
		$rose(conv_ch1);
	endsequence

	sequence s_write_taken;
		addr_phase && hwrite;
	endsequence

	sequence s_read_taken;
		addr_phase && !hwrite;
	endsequence

	sequence s_code0_write;
		state.wr_pend && !state.module_stop && state.wr_addr == OFS_CODE_CH0;
	endsequence

	sequence s_code1_write;
		state.wr_pend && !state.module_stop && state.wr_addr == OFS_CODE_CH1;
	endsequence

	sequence s_ctrl_write;
		state.wr_pend && !state.module_stop && state.wr_addr == OFS_CONTROL;
	endsequence

	// register bus
	AST_READY_ALWAYS: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout == 1'b1)
		else $error("slave inserted a wait");

	AST_RESP_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
		hresp == 1'b0)
		else $error("slave gave an error response");

	AST_WRITE_PEND: assert property (@(posedge hclk) disable iff (!hresetn)
		s_write_taken |=> state.wr_pend && state.wr_addr == $past(haddr))
		else $error("write address not captured");

	AST_RDATA_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
		!addr_phase || hwrite |=> $stable(hrdata))
		else $error("read data moved without a read");

	AST_CODE0_LANDS: assert property (@(posedge hclk) disable iff (!hresetn)
		s_code0_write |=> state.dac_code_ch0 == $past(hwdata[7:0]))
		else $error("channel 0 code write lost");

	AST_CODE1_LANDS: assert property (@(posedge hclk) disable iff (!hresetn)
		s_code1_write |=> state.dac_code_ch1 == $past(hwdata[7:0]))
		else $error("channel 1 code write lost");

	AST_CTRL_LANDS: assert property (@(posedge hclk) disable iff (!hresetn)
		s_ctrl_write |=> state.out_enable_ch1 == $past(hwdata[BIT_OE_CH1]) &&
		state.out_enable_ch0 == $past(hwdata[BIT_OE_CH0]) && state.joint_conv_enable == $past(hwdata[BIT_JOINT]))
		else $error("control write lost");

	AST_MSTOP_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
		state.wr_pend && state.wr_addr == OFS_MODULE_STOP |=> state.module_stop == $past(hwdata[0]))
		else $error("module stop write lost");

	AST_READ_CODE0: assert property (@(posedge hclk) disable iff (!hresetn)
		s_read_taken && !state.module_stop && haddr == OFS_CODE_CH0
		|=> hrdata == {24'h0, $past(state.dac_code_ch0)})
		else $error("channel 0 code read wrong");

	AST_READ_CODE1: assert property (@(posedge hclk) disable iff (!hresetn)
		s_read_taken && !state.module_stop && haddr == OFS_CODE_CH1
		|=> hrdata == {24'h0, $past(state.dac_code_ch1)})
		else $error("channel 1 code read wrong");

	AST_READ_CTRL: assert property (@(posedge hclk) disable iff (!hresetn)
		s_read_taken && !state.module_stop && haddr == OFS_CONTROL
		|=> hrdata == {24'h0, $past(state.out_enable_ch1), $past(state.out_enable_ch0),
		$past(state.joint_conv_enable), 5'h1F})
		else $error("control read wrong");

	AST_READ_STOPPED: assert property (@(posedge hclk) disable iff (!hresetn)
		s_read_taken && state.module_stop && haddr != OFS_MODULE_STOP |=> hrdata == 32'h0)
		else $error("stopped module returned data");

	AST_READ_MSTOP: assert property (@(posedge hclk) disable iff (!hresetn)
		s_read_taken && haddr == OFS_MODULE_STOP |=> hrdata == {31'h0, $past(state.module_stop)})
		else $error("module stop read wrong");

	// reserved bits and reset values
	AST_RESERVED_ONES: assert property (@(posedge hclk) disable iff (!hresetn)
		control_byte(state)[4:0] == 5'h1F)
		else $error("reserved bits not ones");

	AST_CODE_RESET: assert property (@(posedge hclk)
		$rose(hresetn) |-> state.dac_code_ch0 == 8'h00 && state.dac_code_ch1 == 8'h00)
		else $error("codes not zero after reset");

	AST_STOP_RESET: assert property (@(posedge hclk)
		$rose(hresetn) |-> state.module_stop)
		else $error("module stop not set after reset");

	AST_CTRL_RESET: assert property (@(posedge hclk)
		$rose(hresetn) |-> !state.out_enable_ch1 && !state.out_enable_ch0 && !state.joint_conv_enable)
		else $error("control not clear after reset");

	// module stop gate
	AST_NO_CONV_STOPPED: assert property (@(posedge hclk) disable iff (!hresetn)
		state.module_stop |-> !conv_ch0 && !conv_ch1)
		else $error("conversion while stopped");

	AST_STOP_BLOCKS_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
		state.wr_pend && state.module_stop && state.wr_addr != OFS_MODULE_STOP
		|=> $stable(state.dac_code_ch0) && $stable(state.dac_code_ch1))
		else $error("write passed module stop");

	AST_STOP_BLOCKS_CTRL: assert property (@(posedge hclk) disable iff (!hresetn)
		state.wr_pend && state.module_stop && state.wr_addr != OFS_MODULE_STOP
		|=> $stable(state.out_enable_ch1) && $stable(state.out_enable_ch0) && $stable(state.joint_conv_enable))
		else $error("control write passed module stop");

	// channel enable table
	AST_JOINT: assert property (@(posedge hclk) disable iff (!hresetn)
		!state.module_stop && state.joint_conv_enable && state.out_enable_ch1 |-> conv_ch0)
		else $error("joint enable failed");

	AST_JOINT_CH1: assert property (@(posedge hclk) disable iff (!hresetn)
		!state.module_stop && state.joint_conv_enable && state.out_enable_ch0 |-> conv_ch1)
		else $error("joint enable failed on channel 1");

	AST_OWN_CH0: assert property (@(posedge hclk) disable iff (!hresetn)
		!state.module_stop && state.out_enable_ch0 |-> conv_ch0)
		else $error("channel 0 enable ignored");

	AST_OWN_CH1: assert property (@(posedge hclk) disable iff (!hresetn)
		!state.module_stop && state.out_enable_ch1 |-> conv_ch1)
		else $error("channel 1 enable ignored");

	AST_SOLO_CH0: assert property (@(posedge hclk) disable iff (!hresetn)
		!state.joint_conv_enable && !state.out_enable_ch0 |-> !conv_ch0)
		else $error("channel 0 converts without enable");

	AST_SOLO_CH1: assert property (@(posedge hclk) disable iff (!hresetn)
		!state.joint_conv_enable && !state.out_enable_ch1 |-> !conv_ch1)
		else $error("channel 1 converts without enable");

	AST_NONE: assert property (@(posedge hclk) disable iff (!hresetn)
		!state.out_enable_ch0 && !state.out_enable_ch1 |-> !conv_ch0 && !conv_ch1)
		else $error("conversion with both enables clear");

	// output side
	AST_DRIVE_OWN: assert property (@(posedge hclk) disable iff (!hresetn)
		analog_out_ch0.drive |-> state.out_enable_ch0)
		else $error("drive without enable");

	AST_DRIVE_OWN1: assert property (@(posedge hclk) disable iff (!hresetn)
		analog_out_ch1.drive |-> state.out_enable_ch1)
		else $error("channel 1 drive without enable");

	AST_NOT_EARLY: assert property (@(posedge hclk) disable iff (!hresetn)
		s_enable_rise0 |-> !analog_out_ch0.valid [*8])
		else $error("result too early");

	AST_NOT_EARLY1: assert property (@(posedge hclk) disable iff (!hresetn)
		s_enable_rise1 |-> !analog_out_ch1.valid [*8])
		else $error("channel 1 result too early");

	AST_CODE_PASSED0: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(analog_out_ch0.valid) |-> analog_out_ch0.code == $past(state.dac_code_ch0))
		else $error("channel 0 code altered");

	AST_CODE_PASSED1: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(analog_out_ch1.valid) |-> analog_out_ch1.code == $past(state.dac_code_ch1))
		else $error("channel 1 code altered");

	AST_RESTART0_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
		s_code0_write |=> state.restart_ch0)
		else $error("channel 0 write did not restart");

	AST_RESTART1_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
		s_code1_write |=> state.restart_ch1)
		else $error("channel 1 write did not restart");

	AST_RESTART_DROPS: assert property (@(posedge hclk) disable iff (!hresetn)
		state.restart_ch0 && conv_ch0 |=> !analog_out_ch0.valid)
		else $error("restart kept valid");

	AST_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
		analog_out_ch1.valid && !state.restart_ch1 && conv_ch1 |=> $stable(analog_out_ch1.code))
		else $error("held code changed");

	AST_HOLD0: assert property (@(posedge hclk) disable iff (!hresetn)
		analog_out_ch0.valid && !state.restart_ch0 && conv_ch0 |=> $stable(analog_out_ch0.code))
		else $error("channel 0 held code changed");

	// standby has no path into the channels, so a result survives it
	AST_STANDBY_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
		standby && analog_out_ch0.valid && conv_ch0 && !state.restart_ch0 |=> analog_out_ch0.valid)
		else $error("standby dropped the output");

	AST_DISABLE: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(state.out_enable_ch1) |-> !analog_out_ch1.drive)
		else $error("output not disabled");

	AST_DISABLE0: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(state.out_enable_ch0) |-> !analog_out_ch0.drive)
		else $error("channel 0 output not disabled");

	AST_DISABLE_DROPS0: assert property (@(posedge hclk) disable iff (!hresetn)
		!conv_ch0 |=> !analog_out_ch0.valid)
		else $error("channel 0 valid kept after disable");

	AST_DISABLE_DROPS1: assert property (@(posedge hclk) disable iff (!hresetn)
		!conv_ch1 |=> !analog_out_ch1.valid)
		else $error("channel 1 valid kept after disable");

endmodule

/* File: verification/dual_dac_control_tb.sv */
`timescale 1ns/1ns
module dual_dac_control_tb;
	import dac_pkg::*;
	// short interval keeps the run brief; the conversion waits derive from it
	localparam int CC = 10;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, standby;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd;
	dac_out_s out0, out1;
	int miscompares, checks_done, n;
	assign hready = hreadyout;
	dual_dac_control #(.CONV_COUNT(CC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .standby(standby), .analog_out_ch0(out0), .analog_out_ch1(out1));
	initial begin
		hclk = 0;
		forever #2 hclk = ~hclk;
	end
	task results;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task wait_rdy;
		int k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			k++;
			if (k > 20) begin
				miscompares++;
				results();
			end
			@(posedge hclk);
		end
	endtask
	// single word transfer: address phase, then data phase
	task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask
	task rdchk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task wait_valid(input int ch);
		n = 0;
		while ((ch == 1 ? out1.valid : out0.valid) !== 1'b1) begin
			n++;
			if (n > 4 * CC) begin
				miscompares++;
				results();
			end
			@(posedge hclk);
			#1;
		end
		chk(32'(n >= CC - 2 && n <= CC + 4), 32'h1);
	endtask
	task t_regs;
		rdchk(OFS_MODULE_STOP, 32'h1);
		bus(1'b1, OFS_CODE_CH0, 32'h77);
		bus(1'b1, OFS_CONTROL, 32'hC0);
		rdchk(OFS_CONTROL, 32'h0);
		chk(32'(out0.valid), 32'h0);
		bus(1'b1, OFS_MODULE_STOP, 32'h0);
		rdchk(OFS_CODE_CH0, 32'h0);
		rdchk(OFS_CODE_CH1, 32'h0);
		rdchk(OFS_CONTROL, 32'h1F);
		bus(1'b1, OFS_CODE_CH1, 32'hFF);
		rdchk(OFS_CODE_CH1, 32'hFF);
		bus(1'b1, OFS_CONTROL, 32'hFF);
		rdchk(OFS_CONTROL, 32'hFF);
		bus(1'b1, OFS_CONTROL, 32'h00);
		rdchk(OFS_CONTROL, 32'h1F);
		rdchk(12'h020, 32'h0);
		$display("test registers done");
	endtask
	task t_conv;
		bus(1'b1, OFS_CODE_CH0, 32'hA5);
		bus(1'b1, OFS_CONTROL, 32'h40);
		#1;
		wait_valid(0);
		chk(32'(out0.code), 32'hA5);
		rdchk(OFS_STATUS, 32'h1);
		chk(32'(out0.drive), 32'h1);
		repeat (2 * CC) @(posedge hclk);
		#1;
		chk(32'({out0.code, out0.valid}), 32'h14B);
		bus(1'b1, OFS_CODE_CH0, 32'h3C);
		repeat (2) @(posedge hclk);
		#1;
		chk(32'(out0.valid), 32'h0);
		wait_valid(0);
		chk(32'(out0.code), 32'h3C);
		bus(1'b1, OFS_CONTROL, 32'h00);
		#1;
		chk(32'(out0.drive), 32'h0);
		$display("test conversion done");
	endtask
	task t_joint;
		bus(1'b1, OFS_CODE_CH1, 32'h5A);
		bus(1'b1, OFS_CONTROL, 32'h60);
		#1;
		wait_valid(1);
		chk(32'(out1.code), 32'h5A);
		chk(32'(out1.drive), 32'h0);
		rdchk(OFS_STATUS, 32'h3);
		bus(1'b1, OFS_CONTROL, 32'h20);
		repeat (2 * CC) @(posedge hclk);
		#1;
		chk(32'({out0.valid, out1.valid, out0.drive}), 32'h0);
		$display("test joint done");
	endtask
	task t_standby;
		bus(1'b1, OFS_CONTROL, 32'h80);
		#1;
		wait_valid(1);
		standby <= 1'b1;
		repeat (3 * CC) @(posedge hclk);
		#1;
		chk(32'({out1.code, out1.drive}), 32'hB5);
		rdchk(OFS_CONTROL, 32'h9F);
		// low supply current wanted: software clears all enables while standby is still set
		bus(1'b1, OFS_CONTROL, 32'h00);
		standby <= 1'b0;
		$display("test standby done");
	endtask
	initial begin
		miscompares = 0;
		checks_done = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 12'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		standby = 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_conv();
		t_joint();
		t_standby();
		results();
	end
endmodule
